// ### inc/gch_defs.svh
`ifndef GCH_DEFS_SVH
`define GCH_DEFS_SVH

// ==========================================================
// command codes written by the host
// ==========================================================
`define GCH_CMD_MEAS_A 8'h03
`define GCH_CMD_MEAS_B 8'h04
`define GCH_CMD_PIN_CTRL 8'h0F
`define GCH_CMD_HIST_EN 8'h30
`define GCH_CMD_HIST_CONT 8'h32

// ==========================================================
// parameter byte fields
// ==========================================================
`define GCH_FIRST_MODE_LSB 0
`define GCH_SECOND_MODE_LSB 4
`define GCH_MASK_ELEC_BIT 1
`define GCH_MASK_SHORT_BIT 4
`define GCH_MASK_DIST_BIT 7
`define GCH_PILE_DIST_BIT 0
`define GCH_PILE_SUM_BIT 1

// ==========================================================
// pin mode codes
// ==========================================================
`define GCH_MODE_OFF 4'h0
`define GCH_MODE_IN_LOW 4'h1
`define GCH_MODE_IN_HIGH 4'h2
`define GCH_MODE_PULSE 4'h3
`define GCH_MODE_LOW 4'h4
`define GCH_MODE_HIGH 4'h5
`define GCH_MODE_DET_HIGH 4'h6
`define GCH_MODE_DET_LOW 4'h7
`define GCH_MODE_OD_NODET 4'h8
`define GCH_MODE_OD_DET 4'h9
`define GCH_MODE_RESET 4'h4

// ==========================================================
// host register map, byte addresses
// ==========================================================
`define GCH_OFS_PARAM_LO 8'h00
`define GCH_OFS_PARAM_HI 8'h04
`define GCH_OFS_CMD 8'h08
`define GCH_OFS_STATUS 8'h0C
`define GCH_STAT_HALT_BIT 0
`define GCH_STAT_KIND_LSB 4
`define GCH_STAT_SCALE_LSB 8
`define GCH_STAT_RUN_BIT 16

`endif

// ### inc/gch_link_if.sv
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// command link between host controller and device
// ==========================================================
interface gch_link_if;
    logic cmdStrobe; // one-cycle command pulse
    logic [7:0] cmdCode; // command code
    gch_pkg::gch_params_t cmdParams; // parameter bytes 4..0
    logic halted; // device waits for readout
    gch_pkg::gch_hist_e haltKind; // kind of halted histogram
    logic [7:0] haltScale; // scale exponent of halted histogram
    logic running; // measurement started

    modport host (
        output cmdStrobe,
        output cmdCode,
        output cmdParams,
        input halted,
        input haltKind,
        input haltScale,
        input running
    );

    modport device (
        input cmdStrobe,
        input cmdCode,
        input cmdParams,
        output halted,
        output haltKind,
        output haltScale,
        output running
    );
endinterface

`default_nettype wire

// ### inc/gch_pkg.sv
package gch_pkg;

    // ==========================================================
    // histogram kinds offered by the measurement engine
    // ==========================================================
    typedef enum logic [2:0] {
        GCH_HIST_NONE,
        GCH_HIST_ELEC,
        GCH_HIST_SHORT,
        GCH_HIST_DIST,
        GCH_HIST_PILE_DIST,
        GCH_HIST_PILE_SUM
    } gch_hist_e;

    typedef logic [3:0] gch_mode_t; // pin mode code
    typedef logic [39:0] gch_params_t; // five parameter bytes, byte 0 low

endpackage

// ### rtl/gch_device.sv
`timescale 1ns/10ps
`default_nettype none
`include "gch_defs.svh"

// What this block does
// - second pin mode from byte 0 bits 7:4
// - mode 1: low aborts, high restarts
// - mode 2: high aborts, low restarts
// - mode 3: pin outputs emitter pulse
// - mode 4 low default, mode 5 high
// - mode 6: high on detection
// - mode 7: low on detection
// - mode 8: open drain, low without detection
// - mode 9: open drain, low on detection
// - host never writes reserved modes 10..15
// - halt when selected histogram becomes available
// - host sends continue after readout
// - continue resumes from halted histogram
// - mask byte 3 bit 1: electrical calibration
// - mask byte 3 bit 4: short distance
// - mask byte 3 bit 7: distance measurement
// - distance histograms carry power-of-two exponent
// - host writes zero to bytes 2, 0
// - pileup byte 1 bit 0: corrected distance
// - pileup byte 1 bit 1: corrected sum
// - host starts measurement after setting masks
// - pin command starts no measurement; first mode
module gch_device (
    gch_link_if.device link,
    input wire logic mclk,
    input wire logic rstn,
    input wire logic pinIn,
    output logic pinOut,
    output logic pinOe,
    input wire logic objDetected,
    input wire logic emitterPulse,
    input wire logic histAvail,
    input wire gch_pkg::gch_hist_e histKind,
    input wire logic [7:0] histScale,
    output logic measStart,
    output logic measAbort,
    output logic collectEn,
    output logic procHold,
    output logic procResume,
    output logic [3:0] firstPinMode
);

    // ==========================================================
    // state
    // ==========================================================
    typedef struct packed {
        gch_pkg::gch_mode_t secondMode; // second pin mode
        gch_pkg::gch_mode_t firstMode; // first pin mode, stored only
        logic [7:0] histMask; // type selection mask
        logic [1:0] pileMask; // pileup selection mask
        logic histEn; // halting readout enabled
        logic running; // a measurement was started
        logic halted; // waiting for host readout
        gch_pkg::gch_hist_e haltKind; // kind that caused the halt
        logic [7:0] haltScale; // exponent of halted histogram
        logic pinOut; // pin drive level
        logic pinOe; // pin drive enable
        logic syncA; // first synchroniser stage
        logic syncB; // second synchroniser stage
        logic measStart; // start pulse
        logic measAbort; // abort pulse
        logic collectEn; // collection allowed
        logic resume; // resume pulse
    } gch_dev_s;

    gch_dev_s state_reg; // registered state
    gch_dev_s state_next; // next state

    logic selected; // offered histogram is selected
    logic gateLevel; // settled pin level in gating sense

    // ==========================================================
    // histogram selection
    // ==========================================================
    // map offered kind onto its mask bit
    always_comb begin
        case (histKind)
            gch_pkg::GCH_HIST_ELEC: begin
                selected = state_reg.histMask[`GCH_MASK_ELEC_BIT];
            end
            gch_pkg::GCH_HIST_SHORT: begin
                selected = state_reg.histMask[`GCH_MASK_SHORT_BIT];
            end
            gch_pkg::GCH_HIST_DIST: begin
                selected = state_reg.histMask[`GCH_MASK_DIST_BIT];
            end
            gch_pkg::GCH_HIST_PILE_DIST: begin
                selected = state_reg.pileMask[`GCH_PILE_DIST_BIT];
            end
            gch_pkg::GCH_HIST_PILE_SUM: begin
                selected = state_reg.pileMask[`GCH_PILE_SUM_BIT];
            end
            default: begin
                selected = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // next state
    // ==========================================================
    always_comb begin
        state_next = state_reg;
        state_next.measStart = 1'b0;
        state_next.measAbort = 1'b0;
        state_next.resume = 1'b0;

        // pin input: only the second stage is looked at
        state_next.syncA = pinIn;
        state_next.syncB = state_reg.syncA;

        // command decode in the cycle of the write
        if (link.cmdStrobe) begin
            case (link.cmdCode)
                `GCH_CMD_PIN_CTRL: begin
                    // pin settings only, no measurement start
                    state_next.firstMode =
                        link.cmdParams[`GCH_FIRST_MODE_LSB +: 4];
                    state_next.secondMode =
                        link.cmdParams[`GCH_SECOND_MODE_LSB +: 4];
                end
                `GCH_CMD_HIST_EN: begin
                    // byte 3 types, byte 1 pileup kinds
                    state_next.histMask = link.cmdParams[31:24];
                    state_next.pileMask = link.cmdParams[9:8];
                    state_next.histEn = 1'b1;
                end
                `GCH_CMD_HIST_CONT: begin
                    if (state_reg.halted) begin
                        state_next.halted = 1'b0;
                        state_next.resume = 1'b1;
                    end
                end
                `GCH_CMD_MEAS_A, `GCH_CMD_MEAS_B: begin
                    state_next.running = 1'b1;
                    state_next.measStart = state_reg.collectEn;
                end
                default: begin
                    // other codes belong to other logic
                end
            endcase
        end

        // halt on a selected histogram; set wins over continue
        if (histAvail && selected && state_reg.histEn &&
                state_reg.running) begin
            state_next.halted = 1'b1;
            state_next.haltKind = histKind;
            // exponent travels only with distance histograms
            if (histKind == gch_pkg::GCH_HIST_DIST) begin
                state_next.haltScale = histScale;
            end else begin
                state_next.haltScale = 8'h00;
            end
        end

        // collection gating from the second pin
        case (state_reg.secondMode)
            `GCH_MODE_IN_LOW, `GCH_MODE_IN_HIGH: begin
                state_next.collectEn = gateLevel;
                if (state_reg.collectEn && !gateLevel) begin
                    state_next.measAbort = state_reg.running;
                end
                if (!state_reg.collectEn && gateLevel) begin
                    state_next.measStart = state_reg.running;
                end
            end
            default: begin
                // leaving an input mode reopens collection
                state_next.collectEn = 1'b1;
            end
        endcase

        // pin drive, registered so the pin never glitches
        case (state_reg.secondMode)
            `GCH_MODE_PULSE: begin
                state_next.pinOut = emitterPulse;
                state_next.pinOe = 1'b1;
            end
            `GCH_MODE_LOW: begin
                state_next.pinOut = 1'b0;
                state_next.pinOe = 1'b1;
            end
            `GCH_MODE_HIGH: begin
                state_next.pinOut = 1'b1;
                state_next.pinOe = 1'b1;
            end
            `GCH_MODE_DET_HIGH: begin
                state_next.pinOut = objDetected;
                state_next.pinOe = 1'b1;
            end
            `GCH_MODE_DET_LOW: begin
                state_next.pinOut = !objDetected;
                state_next.pinOe = 1'b1;
            end
            `GCH_MODE_OD_NODET: begin
                state_next.pinOut = 1'b0;
                state_next.pinOe = !objDetected;
            end
            `GCH_MODE_OD_DET: begin
                state_next.pinOut = 1'b0;
                state_next.pinOe = objDetected;
            end
            default: begin
                // off, input and reserved codes float the pin
                state_next.pinOut = 1'b0;
                state_next.pinOe = 1'b0;
            end
        endcase
    end

    // active level of the gate: true means collection may run
    always_comb begin
        if (state_reg.secondMode == `GCH_MODE_IN_LOW) begin
            gateLevel = state_reg.syncB;
        end else begin
            gateLevel = !state_reg.syncB;
        end
    end

    // ==========================================================
    // registers
    // ==========================================================
    // reset gives constant low drive, the startup default
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= '0;
            state_reg.secondMode <= `GCH_MODE_RESET;
            state_reg.firstMode <= `GCH_MODE_RESET;
            state_reg.pinOe <= 1'b1;
            state_reg.collectEn <= 1'b1;
            state_reg.haltKind <= gch_pkg::GCH_HIST_NONE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ==========================================================
    // outputs, all straight from flops
    // ==========================================================
    assign pinOut = state_reg.pinOut;
    assign pinOe = state_reg.pinOe;
    assign measStart = state_reg.measStart;
    assign measAbort = state_reg.measAbort;
    assign collectEn = state_reg.collectEn;
    assign procHold = state_reg.halted;
    assign procResume = state_reg.resume;
    assign firstPinMode = state_reg.firstMode;
    assign link.halted = state_reg.halted;
    assign link.haltKind = state_reg.haltKind;
    assign link.haltScale = state_reg.haltScale;
    assign link.running = state_reg.running;

endmodule

`default_nettype wire

// ### rtl/gch_host.sv
`timescale 1ns/10ps
`default_nettype none
`include "gch_defs.svh"

// ==========================================================
// host controller: ahb-lite registers to command link
// ==========================================================
module gch_host (
    gch_link_if.host link,
    input wire logic mclk,
    input wire logic rstn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp
);

    typedef struct packed {
        logic [7:0] addr; // latched data-phase address
        logic wrPend; // write data phase pending
        logic [39:0] params; // staged parameter bytes
        logic cmdStrobe; // command pulse to device
        logic [7:0] cmdCode; // last command code
        logic [31:0] rdata; // read data for data phase
    } gch_host_s;

    gch_host_s state_reg; // registered state
    gch_host_s state_next; // next state
    logic take; // address phase accepted
    logic [31:0] status; // status word

    assign take = hsel && htrans[1] && hready;

    // status view of the device; host in software
    always_comb begin
        status = 32'h0000_0000;
        status[`GCH_STAT_HALT_BIT] = link.halted;
        status[`GCH_STAT_KIND_LSB +: 3] = link.haltKind;
        status[`GCH_STAT_SCALE_LSB +: 8] = link.haltScale;
        status[`GCH_STAT_RUN_BIT] = link.running;
    end

    // ==========================================================
    // bus decode and command issue
    // ==========================================================
    always_comb begin
        state_next = state_reg;
        state_next.cmdStrobe = 1'b0;
        // write data lands one cycle after its address phase
        if (state_reg.wrPend) begin
            case (state_reg.addr)
                `GCH_OFS_PARAM_LO: begin
                    state_next.params[31:0] = hwdata;
                end
                `GCH_OFS_PARAM_HI: begin
                    state_next.params[39:32] = hwdata[7:0];
                end
                `GCH_OFS_CMD: begin
                    // code and params reach the device together
                    state_next.cmdCode = hwdata[7:0];
                    state_next.cmdStrobe = 1'b1;
                end
                default: begin
                    // unmapped writes are dropped
                end
            endcase
        end
        state_next.wrPend = take && hwrite;
        state_next.addr = take ? haddr[7:0] : state_reg.addr;
        // read data is prepared in the address phase: zero wait
        state_next.rdata = 32'h0000_0000;
        if (take && !hwrite) begin
            case (haddr[7:0])
                `GCH_OFS_PARAM_LO: begin
                    state_next.rdata = state_reg.params[31:0];
                end
                `GCH_OFS_PARAM_HI: begin
                    state_next.rdata = {24'h000000, state_reg.params[39:32]};
                end
                `GCH_OFS_CMD: begin
                    state_next.rdata = {24'h000000, state_reg.cmdCode};
                end
                `GCH_OFS_STATUS: begin
                    state_next.rdata = status;
                end
                default: begin
                    state_next.rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // registers; hsize is always a word here
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign hrdata = state_reg.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign link.cmdStrobe = state_reg.cmdStrobe;
    assign link.cmdCode = state_reg.cmdCode;
    assign link.cmdParams = state_reg.params;

endmodule

`default_nettype wire

// ### testbench/gch_chk.sv
`timescale 1ns/10ps
`default_nettype none
`include "gch_defs.svh"

// ==========================================================
// link checker beside the host-device command link
// ==========================================================
module gch_chk (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic cmdStrobe,
    input wire logic [7:0] cmdCode,
    input wire logic halted,
    input wire gch_pkg::gch_hist_e haltKind,
    input wire logic [7:0] haltScale,
    input wire logic running,
    input wire logic histAvail,
    input wire logic procHold,
    input wire logic procResume
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    // continue command on the link
    logic contCmd;
    assign contCmd = cmdStrobe && (cmdCode == `GCH_CMD_HIST_CONT);
    // either measurement command on the link
    logic measCmd;
    assign measCmd = cmdStrobe && ((cmdCode == `GCH_CMD_MEAS_A) ||
        (cmdCode == `GCH_CMD_MEAS_B));
    // pin control command on the link
    logic pinCmd;
    assign pinCmd = cmdStrobe && (cmdCode == `GCH_CMD_PIN_CTRL);

    // ==========================================================
    // halt handshake
    // ==========================================================
    a_halt_holds: assert property (halted && !contCmd |=> halted)
        else $error("halt dropped without continue");
    a_cont_resumes: assert property (
        halted && contCmd && !histAvail |=> !halted && procResume)
        else $error("continue did not resume");
    a_resume_cause: assert property (
        procResume |-> $past(halted) && $past(contCmd))
        else $error("resume pulse without halted continue");
    a_halt_cause: assert property (
        $rose(halted) |-> $past(histAvail) && $past(running))
        else $error("halt without available histogram");
    a_hold_equal: assert property (procHold == halted)
        else $error("hold output differs from halt flag");
    // only distance histograms carry an exponent
    a_scale_kind: assert property (
        halted && haltKind != gch_pkg::GCH_HIST_DIST |-> haltScale == 8'h00)
        else $error("scale set on non-distance histogram");

    // ==========================================================
    // command decoding
    // ==========================================================
    a_pin_nostart: assert property (pinCmd && !running |=> !running)
        else $error("pin command started a measurement");
    a_meas_running: assert property (measCmd |=> running)
        else $error("measurement command not taken");

    // main scenarios reached
    c_halt: cover property ($rose(halted));
    c_cont: cover property (halted && contCmd);
    c_meas: cover property (measCmd);
endmodule

`default_nettype wire

// ### testbench/test_gpio_ctrl_histogram_handshake.sv
`timescale 1ns/10ps
`default_nettype none
`include "gch_defs.svh"

// ==========================================================
// bench: ahb-lite host controller driving the device
// ==========================================================
module test_gpio_ctrl_histogram_handshake;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic pinIn = 1'b1;
    logic objDetected = 1'b0;
    logic emitterPulse = 1'b0;
    logic histAvail = 1'b0;
    gch_pkg::gch_hist_e histKind = gch_pkg::GCH_HIST_NONE;
    logic [7:0] histScale = 8'h0;
    logic pinOut, pinOe, measStart, measAbort, collectEn;
    logic procHold, procResume;
    logic [3:0] firstPinMode;
    int nFail = 0;
    int totalChecks = 0;
    int nAbort = 0; // abort pulses seen
    int nStart = 0; // start pulses seen
    int a0, s0;
    // pin rows: mode, detected, pulse, expected out, expected enable
    logic [7:0] rows [14] = '{8'h37, 8'h31, 8'h41, 8'h53, 8'h6B, 8'h61,
        8'h79, 8'h73, 8'h88, 8'h81, 8'h99, 8'h90, 8'h00, 8'h10};

    gch_link_if link ();

    gch_host gch_host_inst (.link(link), .mclk(mclk), .rstn(rstn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));

    gch_device gch_device_inst (.link(link), .mclk(mclk), .rstn(rstn),
        .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
        .objDetected(objDetected), .emitterPulse(emitterPulse),
        .histAvail(histAvail), .histKind(histKind), .histScale(histScale),
        .measStart(measStart), .measAbort(measAbort),
        .collectEn(collectEn), .procHold(procHold),
        .procResume(procResume), .firstPinMode(firstPinMode));

    gch_chk gch_chk_inst (.mclk(mclk), .rstn(rstn),
        .cmdStrobe(link.cmdStrobe), .cmdCode(link.cmdCode),
        .halted(link.halted), .haltKind(link.haltKind),
        .haltScale(link.haltScale), .running(link.running),
        .histAvail(histAvail), .procHold(procHold),
        .procResume(procResume));

    always #20 mclk = ~mclk;

    // pulse counters; pulses stand one cycle only
    always @(posedge mclk) begin
        if (measAbort === 1'b1) nAbort++;
        if (measStart === 1'b1) nStart++;
    end

    // ==========================================================
    // shared tasks
    // ==========================================================
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        totalChecks++;
        if (got !== exp) begin
            nFail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one single word transfer; wait stays open-ended for the watchdog
    task automatic ahb(input logic wr, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q);
        @(posedge mclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask

    // params first so the command sees them whole
    task automatic cmd(input logic [7:0] code, input logic [39:0] p);
        logic [31:0] q;
        ahb(1'b1, `GCH_OFS_PARAM_LO, p[31:0], q);
        ahb(1'b1, `GCH_OFS_PARAM_HI, {24'h0, p[39:32]}, q);
        ahb(1'b1, `GCH_OFS_CMD, {24'h0, code}, q);
        repeat (4) @(posedge mclk);
    endtask

    task automatic stat(input logic [31:0] m, input logic [31:0] exp);
        logic [31:0] q;
        ahb(1'b0, `GCH_OFS_STATUS, 32'h0, q);
        chk(q & m, exp);
    endtask

    task automatic hist(input int k, input logic [7:0] s);
        @(posedge mclk);
        histAvail <= 1'b1;
        histKind <= gch_pkg::gch_hist_e'(k);
        histScale <= s;
        @(posedge mclk);
        histAvail <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask

    task automatic tally_and_finish();
        if (nFail == 0 && totalChecks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // watchdog: tests take roughly 460 cycles
    initial begin
        repeat (6000) @(posedge mclk);
        nFail++;
        tally_and_finish();
    end

    // ==========================================================
    // main sequence
    // ==========================================================
    initial begin
        logic [31:0] q;
        logic [31:0] e;
        repeat (6) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        chk({28'h0, hresp, pinOe, pinOut, collectEn}, 32'h5);
        stat(32'hFFFFFFFF, 32'h0);
        // pin modes from the table, first mode varied alongside
        for (int i = 0; i < 14; i++) begin
            objDetected <= rows[i][3];
            emitterPulse <= rows[i][2];
            // table modes stay below the reserved codes
            cmd(`GCH_CMD_PIN_CTRL, {32'h0, rows[i][7:4],
                4'h9 - rows[i][7:4]});
            chk({31'h0, pinOe}, {31'h0, rows[i][0]});
            e = {31'h0, rows[i][0] & rows[i][1]};
            chk({31'h0, pinOe & pinOut}, e);
            chk({28'h0, firstPinMode}, {28'h0, 4'h9 - rows[i][7:4]});
        end
        stat(32'h00010000, 32'h0);
        // unmapped place reads zero and ignores writes
        ahb(1'b1, 8'h40, 32'hA5A5A5A5, q);
        ahb(1'b0, 8'h40, 32'h0, q);
        chk(q, 32'h0);
        // every kind selected: each halts, continue releases
        cmd(`GCH_CMD_HIST_EN, 40'h0092000300);
        cmd(`GCH_CMD_MEAS_A, 40'h0);
        for (int k = 1; k < 6; k++) begin
            hist(k, 8'h05);
            stat(32'hFFFFFFFF, {15'h0, 1'b1,
                (k == 3) ? 8'h05 : 8'h00, 1'b0, k[2:0], 4'h1});
            cmd(`GCH_CMD_HIST_CONT, 40'h0);
            stat(32'h00010001, 32'h00010000);
        end
        // only distance selected: short and pileup sum pass without halting
        cmd(`GCH_CMD_HIST_EN, 40'h0080000000);
        cmd(`GCH_CMD_MEAS_B, 40'h0);
        hist(2, 8'h00);
        stat(32'h1, 32'h0);
        hist(5, 8'h00);
        stat(32'h1, 32'h0);
        hist(3, 8'h03);
        stat(32'hFFFFFFFF, 32'h00010331);
        cmd(`GCH_CMD_HIST_CONT, 40'h0);
        stat(32'h1, 32'h0);
        // input gating: mode 1 then mode 2, idle level first
        for (int m = 1; m < 3; m++) begin
            pinIn <= (m == 1);
            cmd(`GCH_CMD_PIN_CTRL, {32'h0, m[3:0], 4'h4});
            a0 = nAbort;
            s0 = nStart;
            pinIn <= (m != 1);
            repeat (6) @(posedge mclk);
            chk({31'h0, collectEn}, 32'h0);
            chk(nAbort - a0, 32'h1);
            pinIn <= (m == 1);
            repeat (6) @(posedge mclk);
            chk({31'h0, collectEn}, 32'h1);
            chk(nStart - s0, 32'h1);
        end
        // mid-run reset: startup drive back, run and halt cleared
        rstn <= 1'b0;
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        chk({29'h0, pinOe, pinOut, collectEn}, 32'h5);
        chk({28'h0, firstPinMode}, {28'h0, `GCH_MODE_RESET});
        stat(32'h00010001, 32'h0);
        tally_and_finish();
    end
endmodule

`default_nettype wire
